/* core/ext_data_bus_defs.svh */
/*
  Register offsets, field positions, reset values and timing counts for the
  external memory data bus and its shared port-F pins.
  Assumes a 250 MHz core clock and a plain strobe-based register port.
*/
`ifndef EXT_DATA_BUS_DEFS_SVH
`define EXT_DATA_BUS_DEFS_SVH

// Register word offsets
`define EDB_OFS_CTRL        4'h0
`define EDB_OFS_PORTF_SEL   4'h1
`define EDB_OFS_PORTF_DIR   4'h2
`define EDB_OFS_PORTF_DOUT  4'h3
`define EDB_OFS_PORTF_PIN   4'h4
`define EDB_OFS_PULLUP_EN   4'h5
`define EDB_OFS_RD_DATA     4'h6
`define EDB_OFS_WR_DATA     4'h7
`define EDB_OFS_CMD         4'h8
`define EDB_OFS_STATUS      4'h9

// Control register fields
`define EDB_CTRL_DRIVE_KEEP 0

// Command register fields
`define EDB_CMD_READ        0
`define EDB_CMD_WRITE       1

// Status register fields
`define EDB_STAT_BUSY       0
`define EDB_STAT_RD_DONE    1

// Reset values
`define EDB_RST_CTRL        16'h0000
`define EDB_RST_PORTF_SEL   16'h0000
`define EDB_RST_PORTF_DIR   16'h0000
`define EDB_RST_PORTF_DOUT  16'h0000
`define EDB_RST_PULLUP_EN   16'hFFFF

// Strobe low time in ns and derived cycles at 4 ns period
`define EDB_CLK_PERIOD_NS   4
`define EDB_STROBE_NS       16
`define EDB_STROBE_CYC      ((`EDB_STROBE_NS + `EDB_CLK_PERIOD_NS - 1) / `EDB_CLK_PERIOD_NS)

`endif

/* core/ext_data_bus_pkg.sv */
/*
  Types for the external memory data bus block.
  Assumes the constants header is included by the users as well.
*/
package ext_data_bus_pkg;

  // Bus cycle sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } cycle_state_t;

endpackage : ext_data_bus_pkg

/* core/pin_sync.sv */
/*
  Two-flop synchroniser for a vector of pad inputs.
  Assumes the inputs are asynchronous to mclk.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_r;

  // First stage feeds only the second
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      stage1_r <= '0;
      syncOut  <= '0;
    end
    else
    begin
      stage1_r <= asyncIn;
      syncOut  <= stage1_r;
    end
  end

endmodule : pin_sync

/* core/portf_map.sv */
/*
  Maps data-bus bit order onto port-F bit order and back.
  Assumes a sixteen-line data bus; purely combinational.
*/
`timescale 1ns/1ps
module portf_map (
  input  wire logic [15:0] dataOrder,
  input  wire logic [15:0] portOrder,
  output logic      [15:0] toPort,
  output logic      [15:0] toData
);

  // Lines 0-6 to bits 9-15, 7-14 to 0-7, 15 to 8
  assign toPort = {dataOrder[6:0], dataOrder[15], dataOrder[14:7]};
  assign toData = {portOrder[8], portOrder[7:0], portOrder[15:9]};

endmodule : portf_map

/* core/ext_data_bus.sv */
/*
  External memory data bus with read strobe and shared port-F pins.
  Holds the register file, the bus cycle sequencer and the pad controls.
  Assumes the pad wrapper resolves each pin from out, oe_n and pull-up enable,
  and that address and select pins are owned by neighbours which
  follow busActive and readStrobe_n from this block.
*/
`timescale 1ns/1ps
`include "ext_data_bus_defs.svh"

// How it works
// RL1: Sixteen bidirectional data lines, bits 0 to 15, carry external program and data accesses.
// RL2: With the drive-keep bit clear, the data lines float whenever no external cycle is running.
// RL3: After reset every shared pin is in its data-bus role, not a port pin.
// RL4: A pin switched to port-F use has its own direction bit.
// RL5: Lines 0-6 are port-F bits 9-15, lines 7-14 bits 0-7, and line 15 bit 8.
// RL6: Each pin has a pull-up that is turned off by clearing its port-F pull-up enable bit.
// RL7: The read strobe goes low only in external read cycles.
// RL8: While the read strobe is low the data lines are inputs and the memory drives them.
// RL9: The data on the lines is captured as the read strobe returns high.
// RL10: The strobe qualifies address and selects, and the memory answers only while it is low.
// RL11: The read strobe may drive a memory output enable directly.
// RL12: In write cycles the write strobe is low and all data lines drive the write data. Lines switched to port-F use keep their port direction and value instead.
// RL13: In reset the read strobe is high and the lines undriven, then they take the data-bus role.
module ext_data_bus
  import ext_data_bus_pkg::*;
#(
  parameter int STROBE_CYC = `EDB_STROBE_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWrStb,
  input  wire logic        regRdStb,
  output logic      [15:0] regRdData,
  input  wire logic [15:0] dataPinIn,
  output logic      [15:0] dataPinOut,
  output logic      [15:0] dataPinOe_n,
  output logic      [15:0] dataPullupEn,
  output logic             readStrobe_n,
  output logic             writeStrobe_n,
  output logic             busActive
);

  // Counter wide enough for the whole strobe low time
  localparam int CW = $clog2(STROBE_CYC + 1);

  // Registers
  logic         driveKeep_r;
  logic [15:0]  portSel_r;
  logic [15:0]  portDir_r;
  logic [15:0]  portDout_r;
  logic [15:0]  pullupEn_r;
  logic [15:0]  rdData_r;
  logic [15:0]  wrData_r;
  logic         rdDone_r;
  cycle_state_t state_r;
  cycle_state_t state_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  // Pin input path
  logic [15:0] pinSync;
  logic [15:0] pinPortOrder;
  logic [15:0] selData;
  logic [15:0] dirData;
  logic [15:0] doutData;
  logic [15:0] pullData;

  pin_sync #(
    .WIDTH (16)
  ) u_sync (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .asyncIn (dataPinIn),
    .syncOut (pinSync)
  );

  // Port-F bit order of the sampled pins [RL5]
  portf_map u_map_in (
    .dataOrder (pinSync),
    .portOrder (16'h0000),
    .toPort    (pinPortOrder),
    .toData    ()
  );

  // Port-F registers into data-line order [RL5]
  portf_map u_map_sel (
    .dataOrder (16'h0000),
    .portOrder (portSel_r),
    .toPort    (),
    .toData    (selData)
  );

  portf_map u_map_dir (
    .dataOrder (16'h0000),
    .portOrder (portDir_r),
    .toPort    (),
    .toData    (dirData)
  );

  portf_map u_map_dout (
    .dataOrder (16'h0000),
    .portOrder (portDout_r),
    .toPort    (),
    .toData    (doutData)
  );

  portf_map u_map_pull (
    .dataOrder (16'h0000),
    .portOrder (pullupEn_r),
    .toPort    (),
    .toData    (pullData)
  );

  // Register decode
  wire wrCtrl   = regWrStb && (regAddr == `EDB_OFS_CTRL);
  wire wrSel    = regWrStb && (regAddr == `EDB_OFS_PORTF_SEL);
  wire wrDir    = regWrStb && (regAddr == `EDB_OFS_PORTF_DIR);
  wire wrDout   = regWrStb && (regAddr == `EDB_OFS_PORTF_DOUT);
  wire wrPull   = regWrStb && (regAddr == `EDB_OFS_PULLUP_EN);
  wire wrWdata  = regWrStb && (regAddr == `EDB_OFS_WR_DATA);
  wire wrCmd    = regWrStb && (regAddr == `EDB_OFS_CMD);
  wire rdRdata  = regRdStb && (regAddr == `EDB_OFS_RD_DATA);
  wire idle     = (state_r == ST_IDLE);
  // Commands only start from idle; read wins when both bits are set
  wire startRd  = wrCmd && idle && regWrData[`EDB_CMD_READ];
  wire startWr  = wrCmd && idle && !regWrData[`EDB_CMD_READ] && regWrData[`EDB_CMD_WRITE];
  wire cntDone  = (cnt_r == CW'(STROBE_CYC - 1));
  wire endRead  = (state_r == ST_READ) && cntDone;

  // Sequencer next state; only reads and writes toggle the strobes [RL7]
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = '0;
    unique case (state_r)
      ST_IDLE:
      begin
        if (startRd)
          state_nxt = ST_READ;
        else if (startWr)
          state_nxt = ST_WRITE;
      end
      ST_READ, ST_WRITE:
      begin
        if (cntDone)
          state_nxt = ST_IDLE;
        else
          cnt_nxt = cnt_r + CW'(1);
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Read capture at the strobe's rising edge, from the synchronised pads [RL9]
  // The pads pass two flops first, so the strobe must stay low three cycles
  // or more; the memory holds its data for the whole strobe
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      rdData_r <= 16'h0000;
    else if (endRead)
      rdData_r <= pinSync; // [RL9]
  end

  // Read-done flag: set wins over the clear by a read of the data
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      rdDone_r <= 1'b0;
    else if (endRead)
      rdDone_r <= 1'b1;
    else if (rdRdata)
      rdDone_r <= 1'b0;
  end

  // Software-written registers; reset leaves every pin on the data bus [RL3]
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      driveKeep_r <= 1'b0;
      portSel_r   <= `EDB_RST_PORTF_SEL; // [RL3]
      portDir_r   <= `EDB_RST_PORTF_DIR;
      portDout_r  <= `EDB_RST_PORTF_DOUT;
      pullupEn_r  <= `EDB_RST_PULLUP_EN;
      wrData_r    <= 16'h0000;
    end
    else
    begin
      if (wrCtrl)
        driveKeep_r <= regWrData[`EDB_CTRL_DRIVE_KEEP];
      if (wrSel)
        portSel_r <= regWrData;
      if (wrDir)
        portDir_r <= regWrData; // [RL4]
      if (wrDout)
        portDout_r <= regWrData;
      if (wrPull)
        pullupEn_r <= regWrData; // [RL6]
      if (wrWdata)
        wrData_r <= regWrData;
    end
  end

  // Read mux, data one cycle after the strobe
  logic [15:0] rdMux;
  always_comb
  begin
    unique case (regAddr)
      `EDB_OFS_CTRL:       rdMux = {15'h0000, driveKeep_r};
      `EDB_OFS_PORTF_SEL:  rdMux = portSel_r;
      `EDB_OFS_PORTF_DIR:  rdMux = portDir_r;
      `EDB_OFS_PORTF_DOUT: rdMux = portDout_r;
      `EDB_OFS_PORTF_PIN:  rdMux = pinPortOrder;
      `EDB_OFS_PULLUP_EN:  rdMux = pullupEn_r;
      `EDB_OFS_RD_DATA:    rdMux = rdData_r;
      `EDB_OFS_WR_DATA:    rdMux = wrData_r;
      `EDB_OFS_STATUS:     rdMux = {14'h0000, rdDone_r, !idle};
      default:             rdMux = 16'h0000;
    endcase
  end

  // Read data register, zero outside the answer cycle
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      regRdData <= 16'h0000;
    else if (regRdStb)
      regRdData <= rdMux;
    else
      regRdData <= 16'h0000;
  end

  // Strobe and pad flops so the pins are glitch free
  logic        rdStb_r;
  logic        wrStb_r;
  logic        active_r;
  logic [15:0] out_r;
  logic [15:0] oeN_r;
  logic [15:0] busOeN;
  logic [15:0] padOeN;
  logic [15:0] padOut;

  wire rdNext  = (state_nxt == ST_READ);
  wire wrNext  = (state_nxt == ST_WRITE);
  wire actNext = rdNext || wrNext;

  // Bus lines: drive only for writes, or when kept driven outside cycles [RL2] [RL8] [RL12]
  assign busOeN = (wrNext || (!actNext && driveKeep_r)) ? 16'h0000 : 16'hFFFF;

  // Per-pin choice between bus role and port role [RL1] [RL4]
  assign padOeN = (selData & ~dirData) | (~selData & busOeN);
  assign padOut = (selData & doutData) | (~selData & wrData_r);

  // Strobe and pad registers, idle levels in reset
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rdStb_r  <= 1'b0;     // [RL13]
      wrStb_r  <= 1'b0;
      active_r <= 1'b0;
      out_r    <= 16'h0000;
      oeN_r    <= 16'hFFFF; // [RL13]
    end
    else
    begin
      rdStb_r  <= rdNext;   // [RL7] [RL10]
      wrStb_r  <= wrNext;   // [RL12]
      active_r <= actNext;
      out_r    <= padOut;
      oeN_r    <= padOeN;
    end
  end

  // Pin outputs; strobe suits a memory output enable directly [RL11]
  assign readStrobe_n  = !rdStb_r;
  assign writeStrobe_n = !wrStb_r;
  assign busActive     = active_r;
  assign dataPinOut    = out_r;
  assign dataPinOe_n   = oeN_r;
  assign dataPullupEn  = pullData; // [RL6]

endmodule : ext_data_bus

/* sim/ext_data_bus_props.sv */
/*
  Port checker for the external data bus block.
  Assumes a bind onto ext_data_bus and one mclk domain.
*/
`timescale 1ns/1ps
`include "ext_data_bus_defs.svh"
module ext_data_bus_props #(
  parameter int STROBE_CYC = `EDB_STROBE_CYC
) (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [3:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWrStb,
  input wire logic        regRdStb,
  input wire logic [15:0] regRdData,
  input wire logic [15:0] dataPinIn,
  input wire logic [15:0] dataPinOut,
  input wire logic [15:0] dataPinOe_n,
  input wire logic [15:0] dataPullupEn,
  input wire logic        readStrobe_n,
  input wire logic        writeStrobe_n,
  input wire logic        busActive
);
  logic [7:0]  lowCnt_r;
  logic [15:0] cap_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Strobe low-time count and last pad value seen under the read strobe
  always_ff @(posedge mclk)
  begin
    lowCnt_r <= (readStrobe_n && writeStrobe_n) ? 8'h00 : lowCnt_r + 8'h01;
    if (!rst_n)
      cap_r <= 16'h0000;
    else if (!readStrobe_n)
      cap_r <= dataPinIn;
  end
  property p_excl; !(!readStrobe_n && !writeStrobe_n); endproperty
  a_excl: assert property (p_excl) else $error("both strobes low");
  property p_rdcmd;
    $fell(readStrobe_n) |-> $past(regWrStb && regAddr == `EDB_OFS_CMD && regWrData[`EDB_CMD_READ]);
  endproperty
  a_rdcmd: assert property (p_rdcmd) else $error("read strobe without command");
  property p_len; ($rose(readStrobe_n) || $rose(writeStrobe_n)) |-> lowCnt_r == 8'(STROBE_CYC); endproperty
  a_len: assert property (p_len) else $error("strobe length wrong");
  property p_act; busActive == (!readStrobe_n || !writeStrobe_n); endproperty
  a_act: assert property (p_act) else $error("bus active not with strobe");
  property p_rdin; !readStrobe_n |-> dataPinOe_n == 16'hFFFF; endproperty
  a_rdin: assert property (p_rdin) else $error("lines driven during read");
  property p_wrout; !writeStrobe_n |-> dataPinOe_n == 16'h0000; endproperty
  a_wrout: assert property (p_wrout) else $error("lines not driven during write");
  property p_cap; regRdStb && readStrobe_n && regAddr == `EDB_OFS_RD_DATA |=> regRdData == cap_r; endproperty
  a_cap: assert property (p_cap) else $error("read data not captured");
  property p_pull;
    regWrStb && regAddr == `EDB_OFS_PULLUP_EN
    |=> dataPullupEn == {$past(regWrData[8]), $past(regWrData[7:0]), $past(regWrData[15:9])};
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up map wrong");
  property p_rst; $rose(rst_n) |-> readStrobe_n && writeStrobe_n && dataPinOe_n == 16'hFFFF; endproperty
  a_rst: assert property (p_rst) else $error("pins active out of reset");
endmodule : ext_data_bus_props

bind ext_data_bus ext_data_bus_props #(.STROBE_CYC(STROBE_CYC)) props (.mclk, .rst_n, .regAddr, .regWrData,
  .regWrStb, .regRdStb, .regRdData, .dataPinIn, .dataPinOut, .dataPinOe_n, .dataPullupEn, .readStrobe_n,
  .writeStrobe_n, .busActive);

/* sim/ext_mem_model.sv */
/*
  External static memory of one word plus the resolved data lines.
  Assumes address decode lives elsewhere; the bench may drive idle port pins.
*/
`timescale 1ns/1ps
module ext_mem_model (
  input  wire logic        mclk,
  input  wire logic        readStrobe_n,
  input  wire logic        writeStrobe_n,
  input  wire logic [15:0] dataPinOut,
  input  wire logic [15:0] dataPinOe_n,
  input  wire logic [15:0] dataPullupEn,
  input  wire logic        extEn,
  input  wire logic [15:0] extVal,
  output logic      [15:0] pinLevel
);
  logic [15:0] mem_r = 16'h0000;
  logic [15:0] last_r = 16'h0000;
  logic        wrDly_r = 1'b1;
  // Line level: device, memory on output enable, port peer, pull-up, else toggling
  always_comb
    for (int i = 0; i < 16; i++)
      pinLevel[i] = !dataPinOe_n[i] ? dataPinOut[i] : !readStrobe_n ? mem_r[i] :
                    extEn ? extVal[i] : dataPullupEn[i] ? 1'b1 : ~last_r[i];
  // Latch bus data as the write strobe rises
  always_ff @(posedge mclk)
  begin
    last_r  <= pinLevel;
    wrDly_r <= writeStrobe_n;
    if (writeStrobe_n && !wrDly_r)
      mem_r <= last_r;
  end
endmodule : ext_mem_model

/* sim/testbench.sv */
/*
  Scenario testbench for the external data bus block.
  Assumes the memory model on the pins and the bound checker.
*/
`timescale 1ns/1ps
`include "ext_data_bus_defs.svh"
module testbench;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0000;
  logic        regWrStb = 1'b0;
  logic        regRdStb = 1'b0;
  logic        extEn = 1'b0;
  logic [15:0] extVal = 16'h0000;
  logic [15:0] regRdData, dataPinIn, dataPinOut, dataPinOe_n, dataPullupEn;
  logic        readStrobe_n, writeStrobe_n, busActive;
  int          badCount = 0;
  int          numChecks = 0;

  always #2 mclk = ~mclk;

  ext_data_bus #(.STROBE_CYC(4)) dut (.mclk, .rst_n, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
    .dataPinIn, .dataPinOut, .dataPinOe_n, .dataPullupEn, .readStrobe_n, .writeStrobe_n, .busActive);
  ext_mem_model mem (.mclk, .readStrobe_n, .writeStrobe_n, .dataPinOut, .dataPinOe_n, .dataPullupEn,
    .extEn, .extVal, .pinLevel(dataPinIn));

  // Port-F order to data-line order
  function automatic logic [15:0] toData(input logic [15:0] p);
    return {p[8], p[7:0], p[15:9]};
  endfunction : toData

  task automatic conclude;
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      badCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge mclk);
    regWrStb <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge mclk);
    regRdStb <= 1'b0;
    #1 chk(regRdData, e);
    @(posedge mclk);
  endtask : rd

  task automatic waitIdle;
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      #1 n++;
    end
    while (busActive !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      badCount++;
      conclude();
    end
    @(posedge mclk);
  endtask : waitIdle

  task automatic sReset;
    chk(readStrobe_n, 1'b1);
    chk(writeStrobe_n, 1'b1);
    chk(busActive, 1'b0);
    chk(dataPinOe_n, 16'hFFFF);
    chk(dataPullupEn, 16'hFFFF);
    rd(`EDB_OFS_PORTF_SEL, 16'h0000);
    rd(4'hF, 16'h0000);
  endtask : sReset

  task automatic sWriteRead;
    wr(`EDB_OFS_WR_DATA, 16'hA5C3);
    wr(`EDB_OFS_CMD, 16'h0002);
    #1 chk(writeStrobe_n, 1'b0);
    chk(dataPinOut, 16'hA5C3);
    chk(dataPinOe_n, 16'h0000);
    waitIdle();
    chk(dataPinOe_n, 16'hFFFF);
    wr(`EDB_OFS_CMD, 16'h0001);
    #1 chk(readStrobe_n, 1'b0);
    chk(dataPinOe_n, 16'hFFFF);
    waitIdle();
    rd(`EDB_OFS_STATUS, 16'h0002);
    rd(`EDB_OFS_RD_DATA, 16'hA5C3);
    rd(`EDB_OFS_STATUS, 16'h0000);
    rd(`EDB_OFS_WR_DATA, 16'hA5C3);
    wr(`EDB_OFS_CMD, 16'h0003);
    #1 chk(readStrobe_n, 1'b0);
    wr(`EDB_OFS_CMD, 16'h0002);
    #1 chk(writeStrobe_n, 1'b1);
    chk(readStrobe_n, 1'b0);
    waitIdle();
    chk(writeStrobe_n, 1'b1);
    rd(`EDB_OFS_RD_DATA, 16'hA5C3);
  endtask : sWriteRead

  task automatic sDriveKeep;
    wr(`EDB_OFS_CTRL, 16'h0001);
    #1 chk(dataPinOe_n, 16'h0000);
    chk(dataPinOut, 16'hA5C3);
    rd(`EDB_OFS_CTRL, 16'h0001);
    wr(`EDB_OFS_CTRL, 16'h0000);
    #1 chk(dataPinOe_n, 16'hFFFF);
  endtask : sDriveKeep

  task automatic sPort;
    wr(`EDB_OFS_PORTF_SEL, 16'hFFFF);
    wr(`EDB_OFS_PORTF_DIR, 16'h00FF);
    wr(`EDB_OFS_PORTF_DOUT, 16'h1234);
    #1 chk(dataPinOe_n, ~toData(16'h00FF));
    chk(dataPinOut & toData(16'h00FF), toData(16'h0034));
    extEn <= 1'b1;
    extVal <= toData(16'hAB00);
    repeat (4) @(posedge mclk);
    rd(`EDB_OFS_PORTF_PIN, 16'hAB34);
    extEn <= 1'b0;
    wr(`EDB_OFS_PORTF_SEL, 16'h0000);
  endtask : sPort

  task automatic sPullup;
    wr(`EDB_OFS_PULLUP_EN, 16'hFEFF);
    #1 chk(dataPullupEn, 16'h7FFF);
    rd(`EDB_OFS_PULLUP_EN, 16'hFEFF);
    wr(`EDB_OFS_PULLUP_EN, 16'hFFFF);
  endtask : sPullup

  // Reset in the middle of a read; held long enough to cover the strobe release
  task automatic sMidReset;
    wr(`EDB_OFS_CMD, 16'h0001);
    rst_n <= 1'b0;
    @(posedge mclk);
    #1 chk(readStrobe_n, 1'b1);
    chk(busActive, 1'b0);
    chk(dataPinOe_n, 16'hFFFF);
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1 rd(`EDB_OFS_STATUS, 16'h0000);
    rd(`EDB_OFS_RD_DATA, 16'h0000);
  endtask : sMidReset

  // Reset, then the scenarios in turn
  initial
  begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1 sReset();
    sWriteRead();
    sDriveKeep();
    sPort();
    sPullup();
    sMidReset();
    conclude();
  end
endmodule : testbench
